// [pkg/rx_perf_pkg.sv]
package rx_perf_pkg;
  // ****************************************************************
  // Register map (printed offsets not all multiples of four: index)
  // ****************************************************************
  localparam logic [8:0] IDX_GOOD_B0   = 9'h118;
  localparam logic [8:0] IDX_GOOD_B1   = 9'h119;
  localparam logic [8:0] IDX_GOOD_B2   = 9'h11a;
  localparam logic [8:0] IDX_GOOD_B3   = 9'h11b;
  localparam logic [8:0] IDX_ABORT_B0  = 9'h11c;
  localparam logic [8:0] IDX_ABORT_B1  = 9'h11d;
  localparam logic [8:0] IDX_ABORT_B2  = 9'h11e;
  localparam logic [8:0] IDX_ABORT_B3  = 9'h11f;
  localparam logic [8:0] IDX_UPD_CTRL  = 9'h120;
  localparam logic [8:0] IDX_UPD_STAT  = 9'h121;
  localparam int         ADDR_W        = 11;
  localparam int         IDX_LSB       = 2;
  localparam int         CNT_W         = 32;
  localparam int         BYTE_LEN_W    = 12;
  localparam int         TRIGGER_BIT   = 0;
  localparam int         DONE_BIT      = 0;
  localparam logic [7:0] REG_RESET     = 8'h00;
  localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
  localparam logic [1:0] RESP_OK       = 2'b00;
  localparam logic [1:0] RESP_DECERR   = 2'b11;

  typedef enum logic [2:0] {
    BUS_IDLE = 3'b001,
    BUS_DONE = 3'b010,
    BUS_WAIT = 3'b100
  } bus_state_e;
endpackage

// [rtl/byte_accumulator.sv]
module byte_accumulator #(
  parameter int CNT_W      = 32,
  parameter int BYTE_LEN_W = 12
) (
  input  wire logic                  mclk_in,
  input  wire logic                  sys_rst_in,
  input  wire logic                  add_in,
  input  wire logic [BYTE_LEN_W-1:0] len_in,
  input  wire logic                  restart_in,
  output logic      [CNT_W-1:0]      total_out,
  output logic      [CNT_W-1:0]      snap_out
);
  logic [CNT_W-1:0] acc_reg;
  logic [CNT_W-1:0] snap_reg;
  wire  [CNT_W-1:0] len_ext = {{(CNT_W-BYTE_LEN_W){1'b0}}, len_in};
  // Bytes arriving in the restart cycle open the new interval
  wire  [CNT_W-1:0] acc_next = restart_in ? (add_in ? len_ext : '0)
                                          : (add_in ? acc_reg + len_ext : acc_reg);
  wire  [CNT_W-1:0] snap_next = restart_in ? acc_reg : snap_reg;

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      acc_reg  <= '0;
      snap_reg <= '0;
    end else begin
      acc_reg  <= acc_next;
      snap_reg <= snap_next;
    end
  end

  assign total_out = acc_reg;
  assign snap_out  = snap_reg;
endmodule // byte_accumulator

// [rtl/rx_pkt_classifier.sv]
module rx_pkt_classifier #(
  parameter int BYTE_LEN_W = 12
) (
  input  wire logic                  mclk_in,
  input  wire logic                  sys_rst_in,
  input  wire logic                  pkt_done_in,
  input  wire logic [BYTE_LEN_W-1:0] pkt_len_in,
  input  wire logic                  pkt_abort_in,
  input  wire logic                  pkt_fcs_err_in,
  input  wire logic                  pkt_size_err_in,
  output logic                       good_add_out,
  output logic                       bad_add_out,
  output logic      [BYTE_LEN_W-1:0] len_out
);
  // Any error class counts as aborted for byte accounting
  wire bad_pkt = pkt_abort_in | pkt_fcs_err_in | pkt_size_err_in;

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      good_add_out <= 1'b0;
      bad_add_out  <= 1'b0;
      len_out      <= '0;
    end else begin
      good_add_out <= pkt_done_in & ~bad_pkt;
      bad_add_out  <= pkt_done_in & bad_pkt;
      len_out      <= pkt_len_in;
    end
  end
endmodule // rx_pkt_classifier

// [rtl/rx_serial_byte_perf_counters.sv]
// How it works
// - Count bytes of unaborted stored packets
// - Separately count bytes of aborted packets
// - Discarded bytes may still be counted
// - Each count read as four bytes
// - Trigger rise latches counts, restarts counters
// - Update touches only these serial counters
// - Trigger is bit 0, others unused
// - Done flag sets, clears with trigger low
// - FCS, abort, size errors count aborted
//
// Added by the designer: register access over Avalon-MM.
module rx_serial_byte_perf_counters #(
  parameter int BYTE_LEN_W = 12
) (
  input  wire logic                           mclk_in,
  input  wire logic                           sys_rst_in,
  input  wire logic [rx_perf_pkg::ADDR_W-1:0] avs_address_in,
  input  wire logic                           avs_read_in,
  input  wire logic                           avs_write_in,
  input  wire logic [31:0]                    avs_writedata_in,
  input  wire logic [3:0]                     avs_byteenable_in,
  input  wire logic                           pkt_done_in,
  input  wire logic [BYTE_LEN_W-1:0]          pkt_len_in,
  input  wire logic                           pkt_abort_in,
  input  wire logic                           pkt_fcs_err_in,
  input  wire logic                           pkt_size_err_in,
  output logic      [31:0]                    avs_readdata_out,
  output logic                                avs_waitrequest_out,
  output logic      [1:0]                     avs_response_out,
  output logic                                rx_perf_update_done_out
);
  import rx_perf_pkg::*;

  // ****************************************************************
  // Packet intake
  // ****************************************************************
  logic                  good_add;
  logic                  bad_add;
  logic [BYTE_LEN_W-1:0] cls_len;

  // Dropped bytes are counted at write time, not subtracted later
  rx_pkt_classifier #(.BYTE_LEN_W(BYTE_LEN_W)) u_cls (
    .mclk_in         (mclk_in),
    .sys_rst_in      (sys_rst_in),
    .pkt_done_in     (pkt_done_in),
    .pkt_len_in      (pkt_len_in),
    .pkt_abort_in    (pkt_abort_in),
    .pkt_fcs_err_in  (pkt_fcs_err_in),
    .pkt_size_err_in (pkt_size_err_in),
    .good_add_out    (good_add),
    .bad_add_out     (bad_add),
    .len_out         (cls_len)
  );

  // ****************************************************************
  // Update control
  // ****************************************************************
  logic       trigger_reg;
  logic       trigger_prev_reg;
  logic       done_reg;
  logic       restart_reg;
  logic [7:0] upd_ctrl_reg;

  wire trigger_rise = trigger_reg & ~trigger_prev_reg;

  // ****************************************************************
  // Counters
  // ****************************************************************
  logic [CNT_W-1:0] good_snap;
  logic [CNT_W-1:0] bad_snap;

  // Restart belongs to this block only; other interfaces unaffected
  byte_accumulator #(.CNT_W(CNT_W), .BYTE_LEN_W(BYTE_LEN_W)) u_good (
    .mclk_in    (mclk_in),
    .sys_rst_in (sys_rst_in),
    .add_in     (good_add),
    .len_in     (cls_len),
    .restart_in (restart_reg),
    .total_out  (),
    .snap_out   (good_snap)
  );

  byte_accumulator #(.CNT_W(CNT_W), .BYTE_LEN_W(BYTE_LEN_W)) u_bad (
    .mclk_in    (mclk_in),
    .sys_rst_in (sys_rst_in),
    .add_in     (bad_add),
    .len_in     (cls_len),
    .restart_in (restart_reg),
    .total_out  (),
    .snap_out   (bad_snap)
  );

  // ****************************************************************
  // Avalon-MM slave
  // ****************************************************************
  bus_state_e bus_state_reg;
  bus_state_e bus_state_next;
  logic [31:0] rdata_reg;
  logic [1:0]  resp_reg;

  wire [8:0] idx      = avs_address_in[ADDR_W-1:IDX_LSB];
  wire       req      = avs_read_in | avs_write_in;
  wire       accept   = (bus_state_reg == BUS_IDLE) & req;
  // Answer cycle: waitrequest is low while the state is BUS_DONE
  wire       answer   = (bus_state_reg == BUS_DONE);
  wire       hit_good = (idx >= IDX_GOOD_B0) & (idx <= IDX_GOOD_B3);
  wire       hit_bad  = (idx >= IDX_ABORT_B0) & (idx <= IDX_ABORT_B3);
  wire       hit_ctrl = (idx == IDX_UPD_CTRL);
  wire       hit_stat = (idx == IDX_UPD_STAT);
  wire       mapped   = hit_good | hit_bad | hit_ctrl | hit_stat;
  wire [1:0] lane     = idx[1:0];
  // Low index selects bits 7:0, high selects 31:24
  wire [7:0] good_byte = good_snap[{lane, 3'b000} +: 8];
  wire [7:0] bad_byte  = bad_snap[{lane, 3'b000} +: 8];
  wire [7:0] stat_byte = {7'b000_0000, done_reg};
  wire [7:0] sel_byte  = hit_good ? good_byte :
                         hit_bad  ? bad_byte :
                         hit_ctrl ? upd_ctrl_reg :
                         hit_stat ? stat_byte : 8'h00;
  // Reads only select; nothing changes on a read
  wire [31:0] rd_word = mapped ? {24'h00_0000, sel_byte} : UNMAPPED_DATA;
  // Write lands at the edge the master sees waitrequest low
  wire        ctrl_wr = answer & avs_write_in & hit_ctrl & avs_byteenable_in[0];
  // Upper bits unused and held at zero
  wire [7:0]  ctrl_next = ctrl_wr ? {7'b000_0000, avs_writedata_in[TRIGGER_BIT]}
                                  : upd_ctrl_reg;

  always_comb begin
    case (bus_state_reg)
      BUS_IDLE: bus_state_next = req ? BUS_DONE : BUS_IDLE;
      BUS_DONE: bus_state_next = BUS_WAIT;
      BUS_WAIT: bus_state_next = BUS_IDLE;
      default:  bus_state_next = BUS_IDLE;
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      bus_state_reg       <= BUS_IDLE;
      rdata_reg           <= 32'h0000_0000;
      resp_reg            <= RESP_OK;
      avs_waitrequest_out <= 1'b1;
    end else begin
      bus_state_reg       <= bus_state_next;
      // Waitrequest drops one cycle after the request is taken
      avs_waitrequest_out <= ~accept;
      if (accept) begin
        rdata_reg <= avs_read_in ? rd_word : 32'h0000_0000;
        resp_reg  <= mapped ? RESP_OK : RESP_DECERR;
      end
    end
  end

  assign avs_readdata_out = rdata_reg;
  assign avs_response_out = resp_reg;

  // ****************************************************************
  // Update sequencing
  // ****************************************************************
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      upd_ctrl_reg     <= REG_RESET;
      trigger_reg      <= 1'b0;
      trigger_prev_reg <= 1'b0;
      restart_reg      <= 1'b0;
      done_reg         <= 1'b0;
    end else begin
      upd_ctrl_reg     <= ctrl_next;
      trigger_reg      <= upd_ctrl_reg[TRIGGER_BIT];
      trigger_prev_reg <= trigger_reg;
      restart_reg      <= trigger_rise;
      // Completion sets at the same edge the snapshot lands; set wins over clear
      if (restart_reg) begin
        done_reg <= 1'b1;
      end else if (~upd_ctrl_reg[TRIGGER_BIT]) begin
        done_reg <= 1'b0;
      end
    end
  end

  assign rx_perf_update_done_out = done_reg;
endmodule // rx_serial_byte_perf_counters

// [verification/rx_perf_chk.sv]
module rx_perf_chk (
  input wire logic                           mclk_in,
  input wire logic                           sys_rst_in,
  input wire logic [rx_perf_pkg::ADDR_W-1:0] avs_address_in,
  input wire logic                           avs_read_in,
  input wire logic                           avs_write_in,
  input wire logic [31:0]                    avs_writedata_in,
  input wire logic [3:0]                     avs_byteenable_in,
  input wire logic [31:0]                    avs_readdata_out,
  input wire logic                           avs_waitrequest_out,
  input wire logic [1:0]                     avs_response_out,
  input wire logic                           rx_perf_update_done_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import rx_perf_pkg::*;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);
  wire logic [8:0] idx = avs_address_in[10:2];
  wire logic       ans = !avs_waitrequest_out;
  wire logic       hit = idx >= IDX_GOOD_B0 && idx <= IDX_UPD_STAT;
  wire logic       cw  = ans && avs_write_in && idx == IDX_UPD_CTRL && avs_byteenable_in[0];
  logic            ctrl_reg;
  // Shadow of the trigger bit, seen at the answer edge
  always_ff @(posedge mclk_in)
    if (sys_rst_in) ctrl_reg <= 1'b0;
    else if (cw) ctrl_reg <= avs_writedata_in[0];
  AST_ANSWER_THEN_BUSY: assert property (ans |=> avs_waitrequest_out [*2]) else $error("answer not one cycle");
  AST_ANSWER_BOUNDED: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out |-> ##[1:3] ans)
    else $error("request not answered");
  AST_ANSWER_NEEDS_REQ: assert property (ans |-> avs_read_in || avs_write_in) else $error("answer without request");
  AST_UNMAPPED_ERR: assert property (ans && !hit |-> avs_response_out == RESP_DECERR && avs_readdata_out == 0)
    else $error("unmapped access accepted");
  AST_MAPPED_OK: assert property (ans && hit |-> avs_response_out == RESP_OK) else $error("mapped access refused");
  AST_BYTE_LANE: assert property (ans && avs_read_in |-> avs_readdata_out[31:8] == 24'h00_0000)
    else $error("upper read lanes not zero");
  AST_DATA_HOLD: assert property ($changed(avs_readdata_out) |-> ans) else $error("read data moved");
  AST_DONE_SET: assert property (cw && avs_writedata_in[0] && !ctrl_reg |-> ##[1:6] rx_perf_update_done_out)
    else $error("update never completed");
  AST_DONE_CLEAR: assert property (cw && !avs_writedata_in[0] |-> ##[1:3] !rx_perf_update_done_out)
    else $error("done flag not cleared");
  AST_DONE_CAUSE: assert property ($rose(rx_perf_update_done_out) |-> ctrl_reg)
    else $error("done without trigger");
  AST_DONE_FALL: assert property ($fell(rx_perf_update_done_out) |-> !ctrl_reg) else $error("done fell early");
endmodule // rx_perf_chk

bind rx_serial_byte_perf_counters rx_perf_chk u_chk (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
  .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
  .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
  .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
  .avs_response_out(avs_response_out), .rx_perf_update_done_out(rx_perf_update_done_out));

// [verification/rx_serial_byte_perf_counters_tb_top.sv]
module rx_serial_byte_perf_counters_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import rx_perf_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [10:0] addr = '0;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wdata = '0;
  logic [3:0]  be = 4'h1;
  logic        pdone = 1'b0;
  logic [11:0] plen = '0;
  logic        pab = 1'b0;
  logic        pfcs = 1'b0;
  logic        psz = 1'b0;
  logic [31:0] rdata, good, bad, sg, sb;
  logic        wreq, done;
  logic [1:0]  resp;
  logic [33:0] expq[$];
  logic [31:0] seed = 32'hc7a1_6945;
  int          n_errors = 0;
  int          checked = 0;

  always #20 clk = ~clk;

  rx_serial_byte_perf_counters u_dut (.mclk_in(clk), .sys_rst_in(rst), .avs_address_in(addr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata), .avs_byteenable_in(be),
    .pkt_done_in(pdone), .pkt_len_in(plen), .pkt_abort_in(pab), .pkt_fcs_err_in(pfcs),
    .pkt_size_err_in(psz), .avs_readdata_out(rdata), .avs_waitrequest_out(wreq),
    .avs_response_out(resp), .rx_perf_update_done_out(done));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic cmp(input logic [33:0] e, input logic [33:0] g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  // ****************************************
  // Bus master and read-result monitor
  // ****************************************
  always @(posedge clk)
    if (!rst && rd && wreq === 1'b0) cmp(expq.pop_front(), {resp, rdata});

  task automatic bus(input logic w, input logic [8:0] i, input logic [7:0] d, input logic [33:0] e);
    int n;
    n = 0;
    if (!w) expq.push_back(e);
    @(posedge clk);
    seed = lfsr(seed);
    addr <= {i, 2'b00};
    rd <= !w;
    wr <= w;
    wdata <= {seed[31:8], d};
    // Data bit 7 set withholds lane 0, so a control write is ignored
    be <= {seed[3:1], ~d[7]};
    do begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 20);
    if (n >= 20) n_errors++;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic rdb(input logic [8:0] i, input logic [7:0] d);
    bus(1'b0, i, 8'h00, {RESP_OK, 24'h00_0000, d});
  endtask

  task automatic rdcnt(input logic [8:0] b, input logic [31:0] v);
    for (int k = 0; k < 4; k++) rdb(b + 9'(k), v[8*k +: 8]);
  endtask

  // Back-to-back packets: clean, then abort, FCS and size error in turn
  task automatic pkts(input int n);
    for (int k = 0; k < n; k++) begin
      @(posedge clk);
      seed = lfsr(seed);
      pdone <= 1'b1;
      plen <= seed[11:0];
      pab <= k % 4 == 1;
      pfcs <= k % 4 == 2;
      psz <= k % 4 == 3;
      if (k % 4 == 0) good += seed[11:0];
      else bad += seed[11:0];
    end
    @(posedge clk);
    pdone <= 1'b0;
  endtask

  task automatic update();
    bus(1'b1, IDX_UPD_CTRL, 8'h00, '0);
    bus(1'b1, IDX_UPD_CTRL, 8'h01, '0);
    repeat (5) @(posedge clk);
  endtask

  task automatic stop_test();
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ****************************************
  // Scenarios and watchdog
  // ****************************************
  initial begin
    repeat (30000) @(posedge clk);
    n_errors++;
    stop_test();
  end

  initial begin
    good = 0;
    bad = 0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 10; i++) rdb(IDX_GOOD_B0 + 9'(i), REG_RESET);
    bus(1'b0, 9'h117, 8'h00, {RESP_DECERR, UNMAPPED_DATA});
    bus(1'b0, 9'h122, 8'h00, {RESP_DECERR, UNMAPPED_DATA});
    pkts(40);
    bus(1'b1, IDX_GOOD_B0, 8'hff, '0);
    bus(1'b1, IDX_UPD_CTRL, 8'h81, '0);
    rdb(IDX_UPD_CTRL, 8'h00);
    rdcnt(IDX_GOOD_B0, 32'h0000_0000);
    update();
    rdb(IDX_UPD_STAT, 8'h01);
    @(negedge clk);
    cmp(34'h0_0000_0001, {33'h0_0000_0000, done});
    rdb(IDX_UPD_CTRL, 8'h01);
    rdcnt(IDX_GOOD_B0, good);
    rdcnt(IDX_ABORT_B0, bad);
    sg = good;
    sb = bad;
    good = 0;
    bad = 0;
    pkts(23);
    rdcnt(IDX_GOOD_B0, sg);
    rdcnt(IDX_ABORT_B0, sb);
    update();
    rdcnt(IDX_GOOD_B0, good);
    rdcnt(IDX_ABORT_B0, bad);
    bus(1'b1, IDX_UPD_CTRL, 8'h00, '0);
    rdb(IDX_UPD_STAT, 8'h00);
    @(negedge clk);
    cmp(34'h0_0000_0000, {33'h0_0000_0000, done});
    // Mid-run reset clears running totals as well as snapshots
    pkts(6);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    update();
    rdcnt(IDX_GOOD_B0, 32'h0000_0000);
    rdcnt(IDX_ABORT_B0, 32'h0000_0000);
    stop_test();
  end
endmodule // rx_serial_byte_perf_counters_tb_top
